// ===== rtl/tpw_timing_unit.sv
`timescale 1ns/1ps
module tpw_timing_unit (
    // Clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    // Register port
    input  wire logic [3:0]            addr_in,
    input  wire logic [15:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [15:0]           rdata_out,
    // Phase outputs
    output logic                       phase_a_high_out,
    output logic                       phase_a_low_out,
    output logic                       phase_b_high_out,
    output logic                       phase_b_low_out,
    output logic                       phase_c_high_out,
    output logic                       phase_c_low_out,
    // Sync and latched segment control
    output logic                       period_sync_pulse_out,
    output logic      [8:0]            segment_out
);
    import tpw_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tpw_state_type  state;
        tpw_cfg_type    shadow;
        tpw_cfg_type    active;
        logic           mode_double;
        logic [3:0]     written;
        logic [15:0]    pos;
        logic           half;
        logic [7:0]     sync_cnt;
        logic           sync;
        logic           event_flag;
        logic [15:0]    rdata;
        logic [5:0]     outs;
    } tpw_regs_type;

    tpw_regs_type  st_r;
    tpw_regs_type  st_nxt;
    tpw_pair_type  pair_a;
    tpw_pair_type  pair_b;
    tpw_pair_type  pair_c;
    logic          last_pos;
    logic          fire;

    // ------------------------------------------------------------
    // Phase comparators
    // ------------------------------------------------------------
    tpw_phase u_phase_a (
        .pos_in         (st_r.pos),
        .half_in        (st_r.half),
        .half_period_in (st_r.active.half_period),
        .duty_in        (st_r.active.duty_a),
        .dead_time_in   (st_r.active.dead_time),
        .min_pulse_in   (st_r.active.min_pulse),
        .pair_out       (pair_a)
    );
    tpw_phase u_phase_b (
        .pos_in         (st_r.pos),
        .half_in        (st_r.half),
        .half_period_in (st_r.active.half_period),
        .duty_in        (st_r.active.duty_b),
        .dead_time_in   (st_r.active.dead_time),
        .min_pulse_in   (st_r.active.min_pulse),
        .pair_out       (pair_b)
    );
    tpw_phase u_phase_c (
        .pos_in         (st_r.pos),
        .half_in        (st_r.half),
        .half_period_in (st_r.active.half_period),
        .duty_in        (st_r.active.duty_c),
        .dead_time_in   (st_r.active.dead_time),
        .min_pulse_in   (st_r.active.min_pulse),
        .pair_out       (pair_c)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        last_pos = ({1'b0, st_r.pos} + 17'h00001) >= {1'b0, st_r.active.half_period};
        fire     = 1'b0;
        st_nxt.rdata = 16'h0000;

        // Register writes
        if (wr_in) begin
            case (addr_in)
                ADDR_HALF_PERIOD: begin
                    st_nxt.shadow.half_period = wdata_in;
                    st_nxt.written[0]         = 1'b1;
                end
                ADDR_DEAD_TIME:  st_nxt.shadow.dead_time = wdata_in[9:0];
                ADDR_MIN_PULSE:  st_nxt.shadow.min_pulse = wdata_in;
                ADDR_SYNC_WIDTH: st_nxt.shadow.sync_width = wdata_in[7:0];
                ADDR_DUTY_A: begin
                    st_nxt.shadow.duty_a = wdata_in;
                    st_nxt.written[1]    = 1'b1;
                end
                ADDR_DUTY_B: begin
                    st_nxt.shadow.duty_b = wdata_in;
                    st_nxt.written[2]    = 1'b1;
                end
                ADDR_DUTY_C: begin
                    st_nxt.shadow.duty_c = wdata_in;
                    st_nxt.written[3]    = 1'b1;
                end
                ADDR_MODE_CTRL:  st_nxt.mode_double = wdata_in[MODE_DOUBLE_BIT];
                ADDR_STATUS: begin
                    if (wdata_in[STAT_EVENT_BIT]) begin
                        st_nxt.event_flag = 1'b0;
                    end
                end
                ADDR_SEGMENT:    st_nxt.shadow.segment = wdata_in[SEG_W-1:0];
                default: ;
            endcase
        end

        // Register reads, data in the following cycle only
        if (rd_in) begin
            case (addr_in)
                ADDR_HALF_PERIOD: st_nxt.rdata = st_r.shadow.half_period;
                ADDR_DEAD_TIME:   st_nxt.rdata = {6'h00, st_r.shadow.dead_time};
                ADDR_MIN_PULSE:   st_nxt.rdata = st_r.shadow.min_pulse;
                ADDR_SYNC_WIDTH:  st_nxt.rdata = {8'h00, st_r.shadow.sync_width};
                ADDR_DUTY_A:      st_nxt.rdata = st_r.shadow.duty_a;
                ADDR_DUTY_B:      st_nxt.rdata = st_r.shadow.duty_b;
                ADDR_DUTY_C:      st_nxt.rdata = st_r.shadow.duty_c;
                ADDR_MODE_CTRL:   st_nxt.rdata = 16'(st_r.mode_double) << MODE_DOUBLE_BIT;
                ADDR_STATUS: begin
                    st_nxt.rdata = (16'(st_r.half) << STAT_HALF_BIT)
                                 | (16'(st_r.event_flag) << STAT_EVENT_BIT);
                end
                ADDR_SEGMENT:     st_nxt.rdata = {7'h00, st_r.shadow.segment};
                default:          st_nxt.rdata = 16'h0000;
            endcase
        end

        // Timing engine
        case (st_r.state)
            S_IDLE: begin
                st_nxt.outs = 6'h00;
                if (&st_r.written) begin
                    st_nxt.state = S_RUN;
                    st_nxt.pos   = 16'h0000;
                    st_nxt.half  = 1'b0;
                    fire         = 1'b1;
                end
            end
            S_RUN: begin
                st_nxt.outs = {pair_c.lo, pair_c.hi, pair_b.lo, pair_b.hi,
                               pair_a.lo, pair_a.hi};
                if (last_pos) begin
                    st_nxt.pos  = 16'h0000;
                    st_nxt.half = ~st_r.half;
                    // Period start always, midpoint only in double mode
                    fire = st_r.half || st_r.mode_double;
                end else begin
                    st_nxt.pos = 16'(st_r.pos + 16'h0001);
                end
            end
            default: begin
                st_nxt.state = S_IDLE;
                st_nxt.outs  = 6'h00;
            end
        endcase

        // Sync pulse and latch point
        if (st_r.sync_cnt != 8'h00) begin
            st_nxt.sync_cnt = 8'(st_r.sync_cnt - 8'h01);
        end else begin
            st_nxt.sync = 1'b0;
        end
        if (fire) begin
            st_nxt.active     = st_nxt.shadow;
            st_nxt.sync       = 1'b1;
            st_nxt.sync_cnt   = st_nxt.shadow.sync_width;
            st_nxt.event_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_r                    <= '0;
            st_r.state              <= S_IDLE;
            st_r.shadow.half_period <= HALF_PERIOD_RST;
            st_r.shadow.dead_time   <= DEAD_TIME_RST;
            st_r.shadow.min_pulse   <= MIN_PULSE_RST;
            st_r.shadow.sync_width  <= SYNC_WIDTH_RST;
            st_r.shadow.duty_a      <= DUTY_RST;
            st_r.shadow.duty_b      <= DUTY_RST;
            st_r.shadow.duty_c      <= DUTY_RST;
            st_r.shadow.segment     <= SEGMENT_RST;
            st_r.active.sync_width  <= SYNC_WIDTH_RST;
            st_r.mode_double        <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_out             = st_r.rdata;
    assign phase_a_high_out      = st_r.outs[0];
    assign phase_a_low_out       = st_r.outs[1];
    assign phase_b_high_out      = st_r.outs[2];
    assign phase_b_low_out       = st_r.outs[3];
    assign phase_c_high_out      = st_r.outs[4];
    assign phase_c_low_out       = st_r.outs[5];
    assign period_sync_pulse_out = st_r.sync;
    assign segment_out           = st_r.active.segment;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_pair_no_overlap: assert property (
        !(st_r.outs[0] && st_r.outs[1]) && !(st_r.outs[2] && st_r.outs[3])
        && !(st_r.outs[4] && st_r.outs[5]))
        else $error("complementary outputs on together");

    a_idle_quiet: assert property (
        (st_r.state == S_IDLE) |-> (st_r.outs == 6'h00) && !(&$past(st_r.written)))
        else $error("outputs or run before all writes");

    a_mode_after_reset: assert property (
        $fell(rst_in) |-> !st_r.mode_double)
        else $error("update mode not single after reset");

    a_sync_latches_cfg: assert property (
        $rose(st_r.sync) |-> st_r.active == $past(st_nxt.shadow))
        else $error("settings not latched at sync edge");

    a_segment_latch: assert property (
        $rose(period_sync_pulse_out) |-> segment_out == $past(st_nxt.shadow.segment))
        else $error("segment control not latched at sync edge");

    a_single_one_sync: assert property (
        ($rose(st_r.sync) && !$past(st_r.mode_double) && $past(st_r.state) == S_RUN)
        |-> !st_r.half)
        else $error("midpoint sync in single update mode");

    a_double_mid_sync: assert property (
        (st_r.state == S_RUN && st_r.mode_double && !st_r.half && last_pos
        && st_r.active.half_period > 16'h0001) |=> st_r.sync && st_r.half)
        else $error("no midpoint sync in double update mode");

    a_sync_width_one: assert property (
        ($rose(st_r.sync) && st_r.active.sync_width == 8'h00
        && st_r.active.half_period > 16'h0001) |=> !st_r.sync)
        else $error("sync pulse longer than one cycle");

    a_sync_event_set: assert property (
        $rose(st_r.sync) |-> st_r.event_flag)
        else $error("sync edge did not set event bit");

    a_dead_gap: assert property (
        ($fell(phase_a_high_out) && st_r.active.dead_time != 10'h000
        && $stable(st_r.active)) |-> !phase_a_low_out)
        else $error("low side on without dead time");

    a_pos_range: assert property (
        (st_r.state == S_RUN && st_r.active.half_period != 16'h0000)
        |-> st_r.pos < st_r.active.half_period)
        else $error("position beyond half period");

    a_pos_step: assert property (
        (st_r.state == S_RUN && !last_pos)
        |=> st_r.pos == 16'($past(st_r.pos) + 16'h0001) && $stable(st_r.half))
        else $error("position did not step by one");

    a_half_flip: assert property (
        (st_r.state == S_RUN && last_pos)
        |=> st_r.pos == 16'h0000 && st_r.half != $past(st_r.half))
        else $error("half did not toggle at end of count");

    a_status_half: assert property (
        (rd_in && addr_in == ADDR_STATUS) |=> rdata_out[STAT_HALF_BIT] == $past(st_r.half))
        else $error("status half bit wrong");

    a_sync_count_bound: assert property (
        st_r.sync_cnt <= st_r.active.sync_width)
        else $error("sync counter above latched width");

    a_sync_hold: assert property (
        st_r.sync_cnt != 8'h00 |=> st_r.sync)
        else $error("sync pulse ended early");

    a_sync_end: assert property (
        (st_r.sync && st_r.sync_cnt == 8'h00 && !fire) |=> !st_r.sync)
        else $error("sync pulse too long");

    a_idle_no_sync: assert property (
        (st_r.state == S_IDLE && !(&st_r.written)) |=> !st_r.sync)
        else $error("sync before all writes");

    a_start_fire: assert property (
        (st_r.state == S_IDLE && &st_r.written) |=> st_r.state == S_RUN && st_r.sync)
        else $error("engine did not start after writes");

    a_active_hold: assert property (
        !fire |=> $stable(st_r.active))
        else $error("settings changed away from sync edge");

    a_mode_write: assert property (
        (wr_in && addr_in == ADDR_MODE_CTRL)
        |=> st_r.mode_double == $past(wdata_in[MODE_DOUBLE_BIT]))
        else $error("update mode bit not written");

    a_period_write: assert property (
        (wr_in && addr_in == ADDR_HALF_PERIOD) |=> st_r.shadow.half_period == $past(wdata_in))
        else $error("half period not written");

    a_dead_write: assert property (
        (wr_in && addr_in == ADDR_DEAD_TIME)
        |=> st_r.shadow.dead_time == $past(wdata_in[9:0]))
        else $error("dead time not written");

    a_duty_write: assert property (
        (wr_in && addr_in == ADDR_DUTY_A)
        |=> st_r.shadow.duty_a == $past(wdata_in) && st_r.written[1])
        else $error("duty not written");

    a_event_clear: assert property (
        (wr_in && addr_in == ADDR_STATUS && wdata_in[STAT_EVENT_BIT] && !fire)
        |=> !st_r.event_flag)
        else $error("event bit not cleared");

    a_event_set: assert property (
        fire |=> st_r.event_flag)
        else $error("event bit lost at sync");

    a_zero_dead: assert property (
        (st_r.state == S_RUN && $past(st_r.state) == S_RUN && $stable(st_r.active)
        && st_r.active.dead_time == 10'h000 && st_r.active.min_pulse == 16'h0000
        && st_r.active.duty_a != 16'h0000 && st_r.active.duty_a < st_r.active.half_period)
        |-> phase_a_high_out != phase_a_low_out)
        else $error("edges apart with zero dead time");

    a_width_reset: assert property (
        $fell(rst_in) |-> st_r.shadow.sync_width == SYNC_WIDTH_RST)
        else $error("sync width not at reset value");
endmodule

// ===== rtl/tpw_pkg.sv
package tpw_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_HALF_PERIOD = 4'h0;
    localparam logic [3:0] ADDR_DEAD_TIME   = 4'h1;
    localparam logic [3:0] ADDR_MIN_PULSE   = 4'h2;
    localparam logic [3:0] ADDR_SYNC_WIDTH  = 4'h3;
    localparam logic [3:0] ADDR_DUTY_A      = 4'h4;
    localparam logic [3:0] ADDR_DUTY_B      = 4'h5;
    localparam logic [3:0] ADDR_DUTY_C      = 4'h6;
    localparam logic [3:0] ADDR_MODE_CTRL   = 4'h7;
    localparam logic [3:0] ADDR_STATUS      = 4'h8;
    localparam logic [3:0] ADDR_SEGMENT     = 4'h9;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          MODE_DOUBLE_BIT  = 6;
    localparam int          STAT_HALF_BIT    = 3;
    localparam int          STAT_EVENT_BIT   = 0;
    localparam logic [7:0]  SYNC_WIDTH_RST   = 8'h27;
    localparam logic [15:0] HALF_PERIOD_RST  = 16'h0000;
    localparam logic [9:0]  DEAD_TIME_RST    = 10'h000;
    localparam logic [15:0] MIN_PULSE_RST    = 16'h0000;
    localparam logic [15:0] DUTY_RST         = 16'h0000;
    localparam logic [8:0]  SEGMENT_RST      = 9'h000;
    localparam int          SEG_W            = 9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN  = 2'b10
    } tpw_state_type;

    typedef struct packed {
        logic [15:0] half_period;
        logic [9:0]  dead_time;
        logic [15:0] min_pulse;
        logic [7:0]  sync_width;
        logic [15:0] duty_a;
        logic [15:0] duty_b;
        logic [15:0] duty_c;
        logic [8:0]  segment;
    } tpw_cfg_type;

    typedef struct packed {
        logic hi;
        logic lo;
    } tpw_pair_type;

    // Difference clamped at zero
    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? 16'(a - b) : 16'h0000;
    endfunction
endpackage

// ===== rtl/tpw_phase.sv
`timescale 1ns/1ps
module tpw_phase (
    // Timing position
    input  wire logic [15:0]           pos_in,
    input  wire logic                  half_in,
    // Latched settings
    input  wire logic [15:0]           half_period_in,
    input  wire logic [15:0]           duty_in,
    input  wire logic [9:0]            dead_time_in,
    input  wire logic [15:0]           min_pulse_in,
    // Pair drive
    output tpw_pkg::tpw_pair_type      pair_out
);
    import tpw_pkg::*;

    logic [15:0] duty_cl;
    logic [15:0] dead2;
    logic [15:0] on_hi;
    logic [15:0] on_lo;
    logic        hi_raw;
    logic        lo_raw;

    always_comb begin
        duty_cl = (duty_in > half_period_in) ? half_period_in : duty_in;
        dead2   = {6'h00, dead_time_in};
        // Each edge moves by the dead time, so a pair gap is twice it
        on_hi   = sat_sub(duty_cl, dead2);
        on_lo   = sat_sub(sat_sub(half_period_in, duty_cl), dead2);
        // First half: high opens before the centre; second half: high closes after it
        if (!half_in) begin
            hi_raw = ({1'b0, pos_in} + {1'b0, on_hi}) >= {1'b0, half_period_in};
            lo_raw = pos_in < on_lo;
        end else begin
            hi_raw = pos_in < on_hi;
            lo_raw = ({1'b0, pos_in} + {1'b0, on_lo}) >= {1'b0, half_period_in};
        end
        pair_out.hi = hi_raw && (on_hi >= min_pulse_in) && (on_hi != 16'h0000);
        pair_out.lo = lo_raw && (on_lo >= min_pulse_in) && (on_lo != 16'h0000);
    end
endmodule

// ===== bench/tpw_gate_model.sv
`timescale 1ns/1ps
module tpw_gate_model (
    // Clock
    input  wire logic        sys_clk_in,
    // Pair from the timing unit
    input  wire logic        high_in,
    input  wire logic        low_in,
    // Last completed run lengths and sticky overlap flag
    output logic      [15:0] high_run_out,
    output logic      [15:0] low_run_out,
    output logic      [15:0] gap_run_out,
    output logic             overlap_out
);
    logic [15:0] high_cnt_r;
    logic [15:0] low_cnt_r;
    logic [15:0] idle_cnt_r;
    logic        high_prev_r;
    logic        low_prev_r;

    initial begin
        high_cnt_r = 16'h0000;
        low_cnt_r = 16'h0000;
        idle_cnt_r = 16'h0000;
        high_prev_r = 1'b0;
        low_prev_r = 1'b0;
        high_run_out = 16'h0000;
        low_run_out = 16'h0000;
        gap_run_out = 16'h0000;
        overlap_out = 1'b0;
    end

    // ------------------------------------------------------------
    // Switch on-times and dead gaps seen at the gate drivers
    // ------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        high_prev_r <= high_in;
        low_prev_r <= low_in;
        high_cnt_r <= high_in ? high_cnt_r + 16'h0001 : 16'h0000;
        low_cnt_r <= low_in ? low_cnt_r + 16'h0001 : 16'h0000;
        idle_cnt_r <= (high_in || low_in) ? 16'h0000 : idle_cnt_r + 16'h0001;
        if (high_prev_r && !high_in) begin
            high_run_out <= high_cnt_r;
        end
        if (low_prev_r && !low_in) begin
            low_run_out <= low_cnt_r;
        end
        if ((high_in && !high_prev_r) || (low_in && !low_prev_r)) begin
            gap_run_out <= idle_cnt_r;
        end
        // Both switches on shorts the link
        if (high_in && low_in) begin
            overlap_out <= 1'b1;
        end
    end
endmodule

// ===== bench/three_phase_pwm_timing_unit_test.sv
`timescale 1ns/1ps
module three_phase_pwm_timing_unit_test;
    import tpw_pkg::*;
    logic        sys_clk_in;
    logic        rst_in;
    logic [3:0]  addr_in;
    logic [15:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic [15:0] rdata_out;
    logic        period_sync_pulse_out;
    logic [8:0]  segment_out;
    wire  [2:0]  hi_w;
    wire  [2:0]  lo_w;
    wire  [15:0] hr [0:2];
    wire  [15:0] lr [0:2];
    wire  [15:0] gr [0:2];
    wire  [2:0]  ov;
    int          error_cnt;
    int          n_checks;
    int          sync_cnt;
    int          sync_wc;
    int          sync_gap;
    int          sync_w;
    logic        sync_p;
    logic [15:0] d;
    logic [15:0] s1;
    logic [6:0]  acc;
    logic [8:0]  seg_prev;
    int          duty_v [3] = '{4, 2, 6};

    tpw_timing_unit dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .phase_a_high_out(hi_w[0]), .phase_a_low_out(lo_w[0]),
        .phase_b_high_out(hi_w[1]), .phase_b_low_out(lo_w[1]),
        .phase_c_high_out(hi_w[2]), .phase_c_low_out(lo_w[2]),
        .period_sync_pulse_out(period_sync_pulse_out), .segment_out(segment_out));

    for (genvar g = 0; g < 3; g++) begin : gates
        tpw_gate_model u_gate (.sys_clk_in(sys_clk_in), .high_in(hi_w[g]), .low_in(lo_w[g]),
            .high_run_out(hr[g]), .low_run_out(lr[g]), .gap_run_out(gr[g]),
            .overlap_out(ov[g]));
    end

    // ------------------------------------------------------------
    // Clock, sync monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        sync_cnt = 0;
        sync_wc = 0;
        sync_p = 1'b0;
    end

    always @(posedge sys_clk_in) begin
        if (period_sync_pulse_out && !sync_p) begin
            sync_gap <= sync_cnt;
            sync_cnt = 1;
        end else begin
            sync_cnt = sync_cnt + 1;
        end
        if (period_sync_pulse_out) begin
            sync_wc = sync_wc + 1;
        end else if (sync_p) begin
            sync_w <= sync_wc;
            sync_wc = 0;
        end
        sync_p = period_sync_pulse_out;
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        error_cnt++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        @(posedge sys_clk_in);
        v = rdata_out;
    endtask

    task automatic wait_sync;
        logic p;
        int   n;
        p = period_sync_pulse_out;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk_in);
            if (period_sync_pulse_out && !p) break;
            p = period_sync_pulse_out;
        end
        if (n == 40) begin
            error_cnt++;
            $display("[ERR] %0t no sync pulse", $time);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        addr_in = 4'h0;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd_reg(ADDR_SYNC_WIDTH, d);
        chk(d, 16'h0027);
        rd_reg(ADDR_MODE_CTRL, d);
        chk({15'h0000, d[MODE_DOUBLE_BIT]}, 16'h0000);
        rd_reg(4'hF, d);
        chk(d, 16'h0000);
        wr_reg(ADDR_HALF_PERIOD, 16'hFFFF);
        rd_reg(ADDR_HALF_PERIOD, d);
        chk(d, 16'hFFFF);
        wr_reg(ADDR_DEAD_TIME, 16'hFFFF);
        rd_reg(ADDR_DEAD_TIME, d);
        chk(d, 16'h03FF);
        wr_reg(ADDR_HALF_PERIOD, 16'h0008);
        wr_reg(ADDR_DEAD_TIME, 16'h0001);
        wr_reg(ADDR_SYNC_WIDTH, 16'h0002);
        wr_reg(ADDR_DUTY_A, 16'h0004);
        wr_reg(ADDR_DUTY_B, 16'h0002);
        acc = 7'h00;
        repeat (30) begin
            @(posedge sys_clk_in);
            acc |= {period_sync_pulse_out, hi_w, lo_w};
        end
        chk({9'h000, acc}, 16'h0000);
        wr_reg(ADDR_DUTY_C, 16'h0006);
        repeat (3) wait_sync();
        chk(16'(sync_gap), 16'h0010);
        chk(16'(sync_w), 16'h0003);
        for (int i = 0; i < 3; i++) begin
            chk(hr[i], 16'(2 * (duty_v[i] - 1)));
            chk(lr[i], 16'(2 * (8 - duty_v[i] - 1)));
            chk(gr[i], 16'h0002);
            chk({15'h0000, ov[i]}, 16'h0000);
        end
        rd_reg(ADDR_STATUS, d);
        chk({15'h0000, d[STAT_EVENT_BIT]}, 16'h0001);
        wr_reg(ADDR_STATUS, 16'h0001);
        rd_reg(ADDR_STATUS, d);
        chk({15'h0000, d[STAT_EVENT_BIT]}, 16'h0000);
        wait_sync();
        wr_reg(ADDR_DUTY_A, 16'h0006);
        rd_reg(ADDR_STATUS, d);
        chk({15'h0000, d[STAT_EVENT_BIT]}, 16'h0001);
        wait_sync();
        chk(hr[0], 16'h0006);
        wait_sync();
        chk(hr[0], 16'h000A);
        wr_reg(ADDR_SYNC_WIDTH, 16'h0000);
        wr_reg(ADDR_DEAD_TIME, 16'h0000);
        wr_reg(ADDR_DUTY_A, 16'h0004);
        repeat (3) wait_sync();
        chk(16'(sync_w), 16'h0001);
        chk(gr[0], 16'h0000);
        chk(hr[0], 16'h0008);
        chk(lr[0], 16'h0008);
        wr_reg(ADDR_MIN_PULSE, 16'h0004);
        wr_reg(ADDR_DUTY_A, 16'h0005);
        repeat (2) wait_sync();
        acc = 7'h00;
        repeat (16) begin
            @(posedge sys_clk_in);
            acc[0] = acc[0] | lo_w[0];
        end
        chk({15'h0000, acc[0]}, 16'h0000);
        chk(hr[0], 16'h000A);
        wr_reg(ADDR_MODE_CTRL, 16'h0040);
        rd_reg(ADDR_MODE_CTRL, d);
        chk({15'h0000, d[MODE_DOUBLE_BIT]}, 16'h0001);
        repeat (3) wait_sync();
        chk(16'(sync_gap), 16'h0008);
        rd_reg(ADDR_STATUS, s1);
        wait_sync();
        rd_reg(ADDR_STATUS, d);
        chk({15'h0000, s1[STAT_HALF_BIT] ^ d[STAT_HALF_BIT]}, 16'h0001);
        seg_prev = segment_out;
        for (int k = 0; k < 2; k++) begin
            wait_sync();
            wr_reg(ADDR_SEGMENT, (k == 0) ? 16'h01A5 : 16'h005A);
            chk({7'h00, segment_out}, {7'h00, seg_prev});
            wait_sync();
            seg_prev = (k == 0) ? 9'h1A5 : 9'h05A;
            chk({7'h00, segment_out}, {7'h00, seg_prev});
        end
        complete_run();
    end
endmodule
